// ### logic/usl_pkg.sv
package usl_pkg;

    // ************************************************************
    // Register addresses on the three host address lines
    // ************************************************************
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IEN = 3'h1;
    localparam logic [2:0] ADDR_ISTAT = 3'h2;
    localparam logic [2:0] ADDR_LFC = 3'h3;
    localparam logic [2:0] ADDR_MLC = 3'h4;
    localparam logic [2:0] ADDR_LCS = 3'h5;
    localparam logic [2:0] ADDR_MIS = 3'h6;
    localparam logic [2:0] ADDR_SCR = 3'h7;

    // ************************************************************
    // Field positions and key values
    // ************************************************************
    localparam int LFC_DIV_BIT = 7;
    localparam logic [7:0] LFC_ENH_KEY = 8'hBF;
    localparam int IEN_SLEEP_BIT = 4;
    localparam int EFC_ENH_BIT = 4;
    localparam int MLC_DTR_BIT = 0;
    localparam int MLC_RTS_BIT = 1;
    localparam int MLC_LOOP_BIT = 4;
    localparam int MLC_IR_BIT = 6;
    localparam logic [3:0] ISTAT_NONE = 4'h1;
    localparam logic [3:0] ISTAT_WAKE = 4'h1;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic [7:0] RST_LFC = 8'h00;
    localparam logic [3:0] ZERO4 = 4'h0;

    // ************************************************************
    // Oscillator restart time
    // ************************************************************
    localparam int OSC_START_NS = 2000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int OSC_START_CYC =
        (OSC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic cts;
        logic dsr;
        logic ring_indicator_in;
        logic carrier_detect_in;
    } usl_modem_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } usl_hreq_t;

    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SLEEP,
        PWR_WARM
    } usl_pwr_t;

endpackage : usl_pkg

// ### logic/usl_core.sv
`timescale 1ns/10ps
// Operation
// (RL1) Sleep needs no pending interrupt, sleep enable, zero modem deltas, rx high.
// (RL2) Asleep, the crystal oscillator halts and clocked activity stops.
// (RL3) A falling edge on receive input wakes the device.
// (RL4) A host write to transmit holding wakes the device.
// (RL5) Any change on the four modem inputs wakes the device.
// (RL6) Wake raises interrupt reading 0x1 low nibble; status read clears it.
// (RL7) After servicing the waking cause, sleep resumes automatically.
// (RL8) Host must read modem status to clear modem change before sleeping.
// (RL9) Never sleep while any interrupt is pending.
// (RL10) Keep cycling through sleep until host clears sleep enable.
// (RL11) In infrared mode only clearing sleep enable ends sleep.
// (RL12) Modem control bit 4 selects internal loopback; rest works normally.
// (RL13) In loopback transmit shift output feeds receive shift input.
// (RL14) In loopback tx pin high, rts and dtr deasserted, modem inputs ignored.
// (RL15) No automatic rts/cts flow control during loopback.
// (RL16) Three address lines; enhanced page only while line control is 0xBF.
// (RL17) Line control bit 7 clear: address 0 reads receive, writes transmit.
// (RL18) Divisor page: addresses 0 and 1 are divisor low and high.
// (RL19) Both divisors zero: reads give revision and identity codes.
// (RL20) Enhanced bit set: status addresses write extra feature, pulse width.
// (RL21) Key page: address 2 enhanced function, 4 to 7 flow characters.
// (RL22) Line control at address 3 is reachable on every page.
// (RL23) Modem control bit 6 selects infrared mode.
// (RL24) After wake, hold logic idle until oscillator restart time passes.
// (RL25) Wake indication tracked apart from no-interrupt-pending state.
module usl_core #(
    parameter logic [7:0] REV_CODE = 8'h5A, // Arbitrary value
    parameter logic [7:0] ID_CODE = 8'hA5, // Arbitrary value
    parameter int WARM_CYC = usl_pkg::OSC_START_CYC
) (
    input wire logic sys_clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire usl_pkg::usl_hreq_t host_req, // Host bus request
    output logic [7:0] host_rdata, // Host read data
    input wire logic rx_pin, // Serial receive pin
    output logic tx_pin, // Serial transmit pin
    input wire usl_pkg::usl_modem_t modem_pin_n, // Modem inputs, low active
    output logic rts_out_n, // Request to send, low active
    output logic dtr_out_n, // Terminal ready, low active
    input wire logic tsr_out, // Transmit shift register output
    output logic rsr_in, // Receive shift register input
    input wire logic auto_rts_req, // Datapath auto flow control rts
    output logic auto_flow_en, // Auto rts/cts allowed
    input wire logic [7:0] rx_data, // Receive holding byte
    output logic rx_pop, // Receive holding read strobe
    output logic [7:0] tx_data, // Transmit holding byte
    output logic tx_push, // Transmit holding write strobe
    input wire logic [7:0] line_status, // Line condition status
    input wire logic [3:0] istat_src, // Datapath interrupt source code
    input wire logic dp_irq, // Datapath interrupt pending
    output logic irq, // Interrupt output
    output logic osc_run, // Oscillator enable
    output logic crystal_output_pin, // Crystal output
    output logic logic_run, // Internal clocked logic enable
    output logic ir_mode, // Infrared mode select
    output logic [7:0] baud_div_low, // Divisor low
    output logic [7:0] baud_div_high, // Divisor high
    output logic [7:0] enhanced_function_control, // Enhanced function
    output logic [7:0] extra_feature_control, // Extra feature
    output logic [7:0] optical_pulse_width, // Infrared pulse width
    output logic [7:0] queue_control, // Queue control
    output logic [7:0] resume_char_first, // Flow char
    output logic [7:0] resume_char_second, // Flow char
    output logic [7:0] suspend_char_first, // Flow char
    output logic [7:0] suspend_char_second // Flow char
);

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] rx_sync;
    logic [2:0] mdm_sync [4];
    logic rx_stable;
    usl_pkg::usl_modem_t mdm_stable;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_sync <= 3'h7;
            rx_stable <= 1'b1;
        end else begin
            rx_sync <= {rx_sync[1:0], rx_pin};
            if (rx_sync[1] == rx_sync[2]) begin
                rx_stable <= rx_sync[2];
            end
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_msync
        always_ff @(posedge sys_clk) begin
            if (srst) begin
                mdm_sync[g] <= 3'h7;
                mdm_stable[g] <= 1'b1;
            end else begin
                mdm_sync[g] <= {mdm_sync[g][1:0], modem_pin_n[g]};
                if (mdm_sync[g][1] == mdm_sync[g][2]) begin
                    mdm_stable[g] <= mdm_sync[g][2];
                end
            end
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] line_format_control;
    logic [7:0] interrupt_enables;
    logic [7:0] modem_line_control;
    logic [7:0] scratch_byte;
    logic [3:0] mdm_delta;
    logic [3:0] mdm_prev;
    logic wake_pend;
    usl_pkg::usl_pwr_t pwr;
    logic [$clog2(WARM_CYC + 1)-1:0] warm_cnt;

    wire div_page = line_format_control[usl_pkg::LFC_DIV_BIT]
        && (line_format_control != usl_pkg::LFC_ENH_KEY); // [RL18]
    wire key_page = line_format_control == usl_pkg::LFC_ENH_KEY; // [RL16]
    wire std_page = !line_format_control[usl_pkg::LFC_DIV_BIT]; // [RL17]
    wire enh_on = enhanced_function_control[usl_pkg::EFC_ENH_BIT];
    wire div_zero = (baud_div_low == usl_pkg::ZERO8)
        && (baud_div_high == usl_pkg::ZERO8);
    wire loopback = modem_line_control[usl_pkg::MLC_LOOP_BIT]; // [RL12]
    wire sleep_en = interrupt_enables[usl_pkg::IEN_SLEEP_BIT];
    wire wr = host_req.wr;
    wire rd = host_req.rd;
    wire [2:0] a = host_req.addr;

    // Loopback holds modem inputs idle, pins ignored
    wire [3:0] mdm_view = loopback ? 4'hF : mdm_stable; // [RL14]

    wire wr_lfc = wr && a == usl_pkg::ADDR_LFC; // [RL22]
    wire wr_txh = wr && std_page && a == usl_pkg::ADDR_DATA; // [RL17]
    wire wr_dvl = wr && div_page && a == usl_pkg::ADDR_DATA; // [RL18]
    wire wr_dvh = wr && div_page && a == usl_pkg::ADDR_IEN;
    wire wr_ien = wr && std_page && a == usl_pkg::ADDR_IEN;
    wire wr_qcr = wr && std_page && a == usl_pkg::ADDR_ISTAT;
    wire wr_mlc = wr && std_page && a == usl_pkg::ADDR_MLC;
    wire wr_xfr = wr && std_page && enh_on
        && a == usl_pkg::ADDR_LCS; // [RL20]
    wire wr_ipw = wr && std_page && enh_on && a == usl_pkg::ADDR_MIS;
    wire wr_scb = wr && std_page && a == usl_pkg::ADDR_SCR;
    wire wr_efc = wr && key_page && a == usl_pkg::ADDR_ISTAT; // [RL21]
    wire wr_x1 = wr && key_page && a == usl_pkg::ADDR_MLC;
    wire wr_x2 = wr && key_page && a == usl_pkg::ADDR_LCS;
    wire wr_x3 = wr && key_page && a == usl_pkg::ADDR_MIS;
    wire wr_x4 = wr && key_page && a == usl_pkg::ADDR_SCR;
    wire rd_istat = rd && std_page && a == usl_pkg::ADDR_ISTAT;
    wire rd_mis = rd && std_page && a == usl_pkg::ADDR_MIS; // [RL8]

    wire [3:0] mdm_chg = mdm_view ^ mdm_prev;
    wire irq_any = dp_irq || wake_pend; // [RL25]
    wire sleep_ok = !irq_any && sleep_en && mdm_delta == usl_pkg::ZERO4
        && rx_stable; // [RL1] [RL9]
    wire rx_fall = !rx_stable && rx_sync[2] == 1'b0;
    wire wake_evt = ir_mode ? 1'b0
        : (rx_fall || wr_txh || (mdm_chg != usl_pkg::ZERO4)); // [RL11]

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            line_format_control <= usl_pkg::RST_LFC;
            interrupt_enables <= usl_pkg::ZERO8;
            modem_line_control <= usl_pkg::ZERO8;
            scratch_byte <= usl_pkg::ZERO8;
            baud_div_low <= usl_pkg::ZERO8;
            baud_div_high <= usl_pkg::ZERO8;
            enhanced_function_control <= usl_pkg::ZERO8;
            extra_feature_control <= usl_pkg::ZERO8;
            optical_pulse_width <= usl_pkg::ZERO8;
            queue_control <= usl_pkg::ZERO8;
            resume_char_first <= usl_pkg::ZERO8;
            resume_char_second <= usl_pkg::ZERO8;
            suspend_char_first <= usl_pkg::ZERO8;
            suspend_char_second <= usl_pkg::ZERO8;
            tx_data <= usl_pkg::ZERO8;
        end else begin
            if (wr_lfc) line_format_control <= host_req.wdata;
            if (wr_ien) interrupt_enables <= host_req.wdata; // [RL10]
            if (wr_mlc) modem_line_control <= host_req.wdata;
            if (wr_scb) scratch_byte <= host_req.wdata;
            if (wr_dvl) baud_div_low <= host_req.wdata;
            if (wr_dvh) baud_div_high <= host_req.wdata;
            if (wr_efc) enhanced_function_control <= host_req.wdata;
            if (wr_xfr) extra_feature_control <= host_req.wdata;
            if (wr_ipw) optical_pulse_width <= host_req.wdata;
            if (wr_qcr) queue_control <= host_req.wdata;
            if (wr_x1) resume_char_first <= host_req.wdata;
            if (wr_x2) resume_char_second <= host_req.wdata;
            if (wr_x3) suspend_char_first <= host_req.wdata;
            if (wr_x4) suspend_char_second <= host_req.wdata;
            if (wr_txh) tx_data <= host_req.wdata;
        end
    end

    // ************************************************************
    // Modem deltas, wake flag and power state
    // ************************************************************
    // Set beats the read clear so a change at the read is not lost
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mdm_prev <= 4'hF;
            mdm_delta <= usl_pkg::ZERO4;
            wake_pend <= 1'b0;
        end else begin
            mdm_prev <= mdm_view;
            mdm_delta <= (rd_mis ? usl_pkg::ZERO4 : mdm_delta)
                | mdm_chg; // [RL8]
            if (pwr == usl_pkg::PWR_SLEEP && wake_evt && sleep_en) begin
                wake_pend <= 1'b1; // [RL6]
            end else if (rd_istat) begin
                wake_pend <= 1'b0; // [RL6]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pwr <= usl_pkg::PWR_RUN;
            warm_cnt <= '0;
        end else begin
            unique case (pwr)
                usl_pkg::PWR_RUN: begin
                    if (sleep_ok) pwr <= usl_pkg::PWR_SLEEP; // [RL7] [RL10]
                end
                usl_pkg::PWR_SLEEP: begin
                    if (!sleep_en || wake_evt) begin // [RL3] [RL4] [RL5]
                        pwr <= usl_pkg::PWR_WARM;
                        warm_cnt <= '0;
                    end
                end
                usl_pkg::PWR_WARM: begin
                    warm_cnt <= warm_cnt + 1'b1;
                    if (warm_cnt == ($bits(warm_cnt))'(WARM_CYC - 1)) begin
                        pwr <= usl_pkg::PWR_RUN; // [RL24]
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // Outputs and read mux
    // ************************************************************
    // Host bus stays live in sleep so a transmit holding write can wake it
    assign osc_run = pwr != usl_pkg::PWR_SLEEP; // [RL2]
    assign crystal_output_pin = osc_run & sys_clk; // [RL2]
    assign logic_run = pwr == usl_pkg::PWR_RUN; // [RL2] [RL24]
    assign irq = irq_any;
    assign ir_mode = modem_line_control[usl_pkg::MLC_IR_BIT]; // [RL23]
    assign tx_pin = loopback ? 1'b1 : tsr_out; // [RL14]
    assign rsr_in = loopback ? tsr_out : rx_stable; // [RL13]
    assign auto_flow_en = !loopback; // [RL15]
    assign rts_out_n = loopback ? 1'b1
        : !(modem_line_control[usl_pkg::MLC_RTS_BIT]
            || (auto_flow_en && auto_rts_req)); // [RL14] [RL15]
    assign dtr_out_n = loopback ? 1'b1
        : !modem_line_control[usl_pkg::MLC_DTR_BIT]; // [RL14]
    assign tx_push = wr_txh; // [RL4]
    assign rx_pop = rd && std_page && a == usl_pkg::ADDR_DATA;

    wire [3:0] isrc = dp_irq ? istat_src
        : (wake_pend ? usl_pkg::ISTAT_WAKE : usl_pkg::ISTAT_NONE); // [RL6]
    wire [7:0] mis_val = {~mdm_view[0], ~mdm_view[1],
        ~mdm_view[2], ~mdm_view[3], mdm_delta};
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = usl_pkg::ZERO8;
        if (a == usl_pkg::ADDR_LFC) begin
            next_rdata = line_format_control; // [RL22]
        end else if (key_page) begin
            unique case (a)
                usl_pkg::ADDR_ISTAT: next_rdata = enhanced_function_control;
                usl_pkg::ADDR_MLC: next_rdata = resume_char_first; // [RL21]
                usl_pkg::ADDR_LCS: next_rdata = resume_char_second;
                usl_pkg::ADDR_MIS: next_rdata = suspend_char_first;
                usl_pkg::ADDR_SCR: next_rdata = suspend_char_second;
                default: next_rdata = usl_pkg::ZERO8;
            endcase
        end else if (div_page && a == usl_pkg::ADDR_DATA) begin
            next_rdata = div_zero ? REV_CODE : baud_div_low; // [RL19]
        end else if (div_page && a == usl_pkg::ADDR_IEN) begin
            next_rdata = div_zero ? ID_CODE : baud_div_high; // [RL19]
        end else if (std_page) begin
            unique case (a)
                usl_pkg::ADDR_DATA: next_rdata = rx_data; // [RL17]
                usl_pkg::ADDR_IEN: next_rdata = interrupt_enables;
                usl_pkg::ADDR_ISTAT: next_rdata = {4'h0, isrc};
                usl_pkg::ADDR_MLC: next_rdata = modem_line_control;
                usl_pkg::ADDR_LCS: next_rdata = line_status; // [RL20]
                usl_pkg::ADDR_MIS: next_rdata = mis_val; // [RL20]
                usl_pkg::ADDR_SCR: next_rdata = scratch_byte;
                default: next_rdata = usl_pkg::ZERO8;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) host_rdata <= usl_pkg::ZERO8;
        else if (rd) host_rdata <= next_rdata;
    end

endmodule : usl_core

// ### tb/usl_core_monitor.sv
`timescale 1ns/10ps
module usl_core_monitor #(
    parameter int WARM_CYC = 4
) (
    input wire logic sys_clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire usl_pkg::usl_hreq_t host_req, // Host request
    input wire logic [7:0] host_rdata, // Read data
    input wire logic tx_pin, // Serial out
    input wire logic rts_out_n, // Request to send, low active
    input wire logic dtr_out_n, // Terminal ready, low active
    input wire logic tsr_out, // Shift register out
    input wire logic rsr_in, // Shift register in
    input wire logic auto_flow_en, // Flow control allowed
    input wire logic rx_pop, // Receive read strobe
    input wire logic tx_push, // Transmit write strobe
    input wire logic irq, // Interrupt
    input wire logic osc_run, // Oscillator enable
    input wire logic logic_run, // Logic enable
    input wire logic ir_mode // Infrared mode
);
    // ****************************************
    // Shadow registers
    // ****************************************
    // Shadows follow host writes so page and mode need no internal probes
    logic [7:0] lfc_sh;
    logic ien_sleep;
    logic loop_sh;
    logic [9:0] warm_cnt;
    wire wr_std = host_req.wr && !lfc_sh[usl_pkg::LFC_DIV_BIT];
    wire wr_lfc = host_req.wr && host_req.addr == usl_pkg::ADDR_LFC;
    wire wr_ien = wr_std && host_req.addr == usl_pkg::ADDR_IEN;
    wire wr_mlc = wr_std && host_req.addr == usl_pkg::ADDR_MLC;
    always_ff @(posedge sys_clk) begin
        lfc_sh <= srst ? 8'h00 : (wr_lfc ? host_req.wdata : lfc_sh);
        ien_sleep <= srst ? 1'b0 : (wr_ien ? host_req.wdata[4] : ien_sleep);
        loop_sh <= srst ? 1'b0 : (wr_mlc ? host_req.wdata[4] : loop_sh);
    end
    always_ff @(posedge sys_clk) begin
        if (srst || logic_run) begin
            warm_cnt <= 10'h000;
        end else if (osc_run) begin
            warm_cnt <= warm_cnt + 10'h001;
        end
    end
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence s_tx_wake;
        !osc_run && !ir_mode && wr_std && host_req.addr == usl_pkg::ADDR_DATA;
    endsequence
    sequence s_ir_asleep;
        !osc_run && ir_mode && ien_sleep && !wr_ien;
    endsequence
    a_sleep_entry_ok: assert property ($fell(osc_run) |-> !$past(irq) && $past(ien_sleep))
        else $error("sleep entered without its conditions");
    a_sleep_logic_off: assert property (!osc_run |-> !logic_run)
        else $error("logic running while oscillator stopped");
    a_tx_wake_up: assert property (s_tx_wake |-> ##[1:2] osc_run)
        else $error("transmit write did not wake");
    a_wake_irq_up: assert property ($rose(osc_run) && ien_sleep && !ir_mode |-> ##[0:2] irq)
        else $error("no wake interrupt");
    a_ir_no_wake: assert property (s_ir_asleep |=> !osc_run)
        else $error("infrared sleep left without enable cleared");
    a_loop_flow_off: assert property (auto_flow_en == !loop_sh)
        else $error("flow enable does not follow loopback");
    a_loop_pins_mark: assert property (!auto_flow_en |-> tx_pin && rts_out_n && dtr_out_n)
        else $error("loopback pins not idle");
    a_loop_data_feed: assert property (!auto_flow_en |-> rsr_in == tsr_out)
        else $error("loopback data not fed back");
    a_rx_pop_page: assert property (rx_pop |-> host_req.rd && host_req.addr == usl_pkg::ADDR_DATA && !lfc_sh[7])
        else $error("receive pop off standard page");
    a_tx_push_page: assert property (tx_push |-> wr_std && host_req.addr == usl_pkg::ADDR_DATA)
        else $error("transmit push off standard page");
    a_lfc_readback: assert property (host_req.rd && host_req.addr == usl_pkg::ADDR_LFC |=> host_rdata == $past(lfc_sh))
        else $error("line control read mismatch");
    a_warm_hold_time: assert property ($rose(logic_run) |-> warm_cnt >= WARM_CYC - 1 && warm_cnt <= WARM_CYC + 1)
        else $error("warm-up length wrong");
endmodule : usl_core_monitor

bind usl_core usl_core_monitor #(.WARM_CYC(WARM_CYC)) mon_u (.sys_clk, .srst,
    .host_req, .host_rdata, .tx_pin, .rts_out_n, .dtr_out_n, .tsr_out,
    .rsr_in, .auto_flow_en, .rx_pop, .tx_push, .irq, .osc_run, .logic_run,
    .ir_mode);

// ### tb/usl_host.sv
`timescale 1ns/10ps
module usl_host (
    input wire logic sys_clk, // System clock
    output usl_pkg::usl_hreq_t host_req, // Bus request
    input wire logic [7:0] host_rdata // Read data
);
    initial host_req = '0;
    // ****************************************
    // Bus cycles: strobes last exactly one cycle
    // ****************************************
    task automatic wr(input logic [2:0] a, input logic [7:0] dat);
        @(posedge sys_clk);
        #1;
        host_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: dat};
        @(posedge sys_clk);
        #1;
        host_req.wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] dat);
        @(posedge sys_clk);
        #1;
        host_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        #1;
        host_req.rd = 1'b0;
        dat = host_rdata;
    endtask : rd
    task automatic page_key();
        wr(usl_pkg::ADDR_LFC, usl_pkg::LFC_ENH_KEY);
    endtask : page_key
    task automatic modem_ack();
        logic [7:0] dat;
        rd(usl_pkg::ADDR_MIS, dat);
    endtask : modem_ack
endmodule : usl_host

// ### tb/uart_sleep_loopback_regmap_test.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin \
    checks_done++; \
    if ((got) !== (ex)) begin \
        failures++; \
        $display("ERROR %s expected %h seen %h", nm, ex, got); \
    end \
end
module uart_sleep_loopback_regmap_test;
    localparam logic [7:0] REV = 8'h3C; // Arbitrary value
    localparam logic [7:0] ID = 8'hC3; // Arbitrary value
    localparam int WARM = 4;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic rx_pin = 1'b1;
    logic tsr_out = 1'b1;
    logic dp_irq = 1'b0, auto_rts = 1'b0;
    usl_pkg::usl_modem_t modem_pin_n = 4'hF;
    usl_pkg::usl_hreq_t host_req;
    logic [7:0] host_rdata, tx_data, baud_div_low, baud_div_high, efc, xfc;
    logic [7:0] opw, queue_control, rc1, rc2, sc1, sc2, d;
    logic tx_pin, rts_out_n, dtr_out_n, rsr_in, auto_flow_en, rx_pop;
    logic tx_push, irq, osc_run, crystal_output_pin, logic_run, ir_mode;
    int failures = 0;
    int checks_done = 0;
    int cyc = 0;
    always #5 sys_clk = ~sys_clk;
    usl_host host_u (.sys_clk, .host_req, .host_rdata);
    usl_core #(.REV_CODE(REV), .ID_CODE(ID), .WARM_CYC(WARM)) dut_u (
        .sys_clk, .srst, .host_req, .host_rdata, .rx_pin, .tx_pin,
        .modem_pin_n, .rts_out_n, .dtr_out_n, .tsr_out, .rsr_in,
        .auto_rts_req(auto_rts), .auto_flow_en, .rx_data(8'hA7), .rx_pop,
        .tx_data, .tx_push, .line_status(8'h61), .istat_src(4'h1), .dp_irq,
        .irq, .osc_run, .crystal_output_pin, .logic_run, .ir_mode,
        .baud_div_low, .baud_div_high, .enhanced_function_control(efc),
        .extra_feature_control(xfc), .optical_pulse_width(opw),
        .queue_control, .resume_char_first(rc1), .resume_char_second(rc2),
        .suspend_char_first(sc1), .suspend_char_second(sc2));
    // ****************************************
    // Helpers
    // ****************************************
    task automatic close_out();
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            close_out();
        end
    end
    task automatic wait_osc(input logic lvl);
        int n;
        n = 0;
        while (osc_run !== lvl && n < 300) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        `CHK("osc_run", lvl, osc_run)
    endtask : wait_osc
    // Wake interrupt is cleared once warm-up is over
    task automatic settle_clear();
        repeat (WARM + 4) @(posedge sys_clk);
        host_u.rd(usl_pkg::ADDR_ISTAT, d);
    endtask : settle_clear
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_pages();
        host_u.wr(usl_pkg::ADDR_LFC, 8'h80);
        host_u.rd(usl_pkg::ADDR_DATA, d);
        `CHK("rev", REV, d)
        host_u.rd(usl_pkg::ADDR_IEN, d);
        `CHK("id", ID, d)
        host_u.wr(usl_pkg::ADDR_DATA, 8'h12);
        host_u.wr(usl_pkg::ADDR_IEN, 8'h34);
        host_u.rd(usl_pkg::ADDR_DATA, d);
        `CHK("div_lo", 8'h12, d)
        host_u.rd(usl_pkg::ADDR_IEN, d);
        `CHK("div_hi", 8'h34, d)
        `CHK("div_hi_port", 8'h34, baud_div_high)
        host_u.page_key();
        host_u.wr(usl_pkg::ADDR_ISTAT, 8'h10);
        for (int a = 4; a < 8; a++) host_u.wr(3'(a), 8'h40 + 8'(a));
        for (int a = 4; a < 8; a++) begin
            host_u.rd(3'(a), d);
            `CHK("flow_char", 8'h40 + 8'(a), d)
        end
        `CHK("sc2", 8'h47, sc2)
        `CHK("ir_off", 1'b0, ir_mode)
        host_u.rd(usl_pkg::ADDR_ISTAT, d);
        `CHK("efc", 8'h10, d)
        host_u.rd(usl_pkg::ADDR_LFC, d);
        `CHK("lfc", 8'hBF, d)
        host_u.wr(usl_pkg::ADDR_LFC, 8'h00);
        host_u.wr(usl_pkg::ADDR_ISTAT, 8'h07);
        `CHK("queue", 8'h07, queue_control)
        host_u.wr(usl_pkg::ADDR_LCS, 8'h2D);
        host_u.wr(usl_pkg::ADDR_MIS, 8'h0B);
        `CHK("xfc", 8'h2D, xfc)
        `CHK("pulse", 8'h0B, opw)
        host_u.rd(usl_pkg::ADDR_LCS, d);
        `CHK("lcs", 8'h61, d)
        host_u.rd(usl_pkg::ADDR_DATA, d);
        `CHK("rxh", 8'hA7, d)
        host_u.wr(usl_pkg::ADDR_DATA, 8'h9A);
        `CHK("txh", 8'h9A, tx_data)
        `CHK("div_kept", 8'h12, baud_div_low)
    endtask : t_pages
    task automatic t_loop();
        tsr_out = 1'b0;
        auto_rts = 1'b1;
        host_u.wr(usl_pkg::ADDR_MLC, 8'h13);
        `CHK("tx_mark", 1'b1, tx_pin)
        `CHK("rts_off", 1'b1, rts_out_n)
        `CHK("dtr_off", 1'b1, dtr_out_n)
        `CHK("feed0", 1'b0, rsr_in)
        `CHK("flow_off", 1'b0, auto_flow_en)
        tsr_out = 1'b1;
        #1;
        `CHK("feed1", 1'b1, rsr_in)
        host_u.wr(usl_pkg::ADDR_MLC, 8'h03);
        tsr_out = 1'b0;
        #1;
        `CHK("tx_norm", 1'b0, tx_pin)
        `CHK("rts_on", 1'b0, rts_out_n)
        `CHK("flow_on", 1'b1, auto_flow_en)
        tsr_out = 1'b1;
        host_u.wr(usl_pkg::ADDR_MLC, 8'h00);
        `CHK("auto_rts", 1'b0, rts_out_n)
    endtask : t_loop
    task automatic t_sleep();
        host_u.wr(usl_pkg::ADDR_IEN, 8'h10);
        wait_osc(1'b0);
        `CHK("logic_off", 1'b0, logic_run)
        `CHK("xtal", 1'b0, crystal_output_pin)
        host_u.wr(usl_pkg::ADDR_DATA, 8'h55);
        wait_osc(1'b1);
        repeat (WARM + 4) @(posedge sys_clk);
        `CHK("wake_irq", 1'b1, irq)
        host_u.rd(usl_pkg::ADDR_ISTAT, d);
        `CHK("wake_code", 4'h1, d[3:0])
        `CHK("irq_gone", 1'b0, irq)
        wait_osc(1'b0);
        rx_pin = 1'b0;
        wait_osc(1'b1);
        rx_pin = 1'b1;
        settle_clear();
        wait_osc(1'b0);
        modem_pin_n.cts = 1'b0;
        wait_osc(1'b1);
        settle_clear();
        repeat (20) @(posedge sys_clk);
        `CHK("delta_hold", 1'b1, osc_run)
        host_u.modem_ack();
        wait_osc(1'b0);
        dp_irq = 1'b1;
        host_u.wr(usl_pkg::ADDR_DATA, 8'h66);
        wait_osc(1'b1);
        settle_clear();
        repeat (20) @(posedge sys_clk);
        `CHK("irq_hold", 1'b1, osc_run)
        host_u.wr(usl_pkg::ADDR_MLC, 8'h40);
        `CHK("ir_on", 1'b1, ir_mode)
        dp_irq = 1'b0;
        wait_osc(1'b0);
        rx_pin = 1'b0;
        modem_pin_n.dsr = 1'b0;
        repeat (20) @(posedge sys_clk);
        `CHK("ir_asleep", 1'b0, osc_run)
        rx_pin = 1'b1;
        host_u.wr(usl_pkg::ADDR_IEN, 8'h00);
        wait_osc(1'b1);
        host_u.wr(usl_pkg::ADDR_MLC, 8'h00);
        host_u.modem_ack();
    endtask : t_sleep
    initial begin
        repeat (12) @(posedge sys_clk);
        #1;
        srst = 1'b0;
        t_pages();
        t_loop();
        t_sleep();
        close_out();
    end
endmodule : uart_sleep_loopback_regmap_test
